// ---- logic/clcd_pkg.sv ----
package clcd_pkg;
  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_PS = 8000;
  localparam int EXEC_NS = 18500;
  localparam int EXEC_CYC = (EXEC_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int LONG_NS = 760000;
  localparam int LONG_CYC = (LONG_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  // ---------------------------------------------------------------
  // geometry and addressing
  // ---------------------------------------------------------------
  localparam logic [1:0] IFSEL_PARALLEL = 2'h0;
  localparam logic [6:0] TEXT_DEPTH = 7'h50;
  localparam logic [6:0] LINE_LEN = 7'h28;
  localparam logic [6:0] LINE2_BASE = 7'h40;
  localparam logic [6:0] LINE1_LAST = 7'h27;
  localparam logic [6:0] LINE2_LAST = 7'h67;
  localparam logic [6:0] ONE_ROW_LAST = 7'h4F;
  localparam logic [6:0] SHIFT_MAX_TWO = 7'h27;
  localparam logic [6:0] SHIFT_MAX_ONE = 7'h4F;
  localparam int GLYPH_DEPTH = 64;
  localparam int SEG_W = 40;
  localparam int COM_W = 16;
  localparam logic [2:0] CHR_LAST = 3'h7;
  localparam logic [2:0] DOT_LAST = 3'h4;
  localparam logic [2:0] CURSOR_ROW = 3'h7;
  localparam logic [3:0] ROW_LAST_TWO = 4'hF;
  localparam logic [3:0] ROW_LAST_ONE = 4'h7;
  localparam logic [7:0] SPACE_CODE = 8'h20;
  // ---------------------------------------------------------------
  // commands and fields
  // ---------------------------------------------------------------
  // command class is the position of the highest set bit
  localparam logic [7:0] CMD_TEXT_ADDR = 8'h80;
  localparam logic [7:0] CMD_GLYPH_ADDR = 8'h40;
  localparam logic [7:0] CMD_FUNC = 8'h20;
  localparam logic [7:0] CMD_SHIFT = 8'h10;
  localparam logic [7:0] CMD_DISP = 8'h08;
  localparam logic [7:0] CMD_ENTRY = 8'h04;
  localparam logic [7:0] CMD_HOME = 8'h02;
  localparam logic [7:0] CMD_CLEAR = 8'h01;
  localparam int FS_DL = 4;
  localparam int FS_N = 3;
  localparam int EM_ID = 1;
  localparam int EM_S = 0;
  localparam int DC_D = 2;
  localparam int DC_C = 1;
  localparam int SH_SC = 3;
  localparam int SH_RL = 2;
  localparam logic DL_RST = 1'b1;
  localparam logic N_RST = 1'b1;
  localparam logic ID_RST = 1'b1;
  // ---------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [1:0] ifsel;
    logic rs;
    logic rw;
    logic en;
    logic [7:0] data;
  } clcd_pins_t;
  typedef struct packed {
    logic [COM_W-1:0] com;
    logic [SEG_W-1:0] seg;
  } clcd_panel_t;
  typedef struct packed {
    logic [7:0] code;
    logic [2:0] row;
  } clcd_rom_req_t;
endpackage

// ---- logic/clcd_host_port.sv ----
`timescale 1ns/1ps
// Operation
// [RULE_01] two select pins pick serial or parallel; data_length_bit picks 4 or 8 bit
// [RULE_02] two 8-bit registers: command latch and data latch
// [RULE_03] data transfers go to memory chosen by last address command
// [RULE_04] after a data read the next address byte is loaded automatically
// [RULE_05] after a data write the byte is copied into memory automatically
// [RULE_06] command latch is write-only; never read back
// [RULE_07] select/direction decode: command, status, data write, data read
// [RULE_08] status read gives busy flag on top line, address counter below
// [RULE_09] busy flag high during internal operation; instructions refused then
// [RULE_10] host polls busy flag low before each next instruction
// [RULE_11] busy flag readable only with a parallel bus selected
// [RULE_12] text memory holds up to 80 character codes via address counter
// [RULE_13] each 8-bit code selects one of 256 glyphs, ROM or user memory
// [RULE_14] in two-row mode second row starts at a non-contiguous address
// [RULE_15] display shift offsets screen mapping, stored text unchanged
// [RULE_16] address counter loads from commands, steps one after each data access
// [RULE_17] 16 commons two-row, 8 commons one-row, 40 segments always
// [RULE_18] dots shift serially into 40-bit chain then latch into holding latch
// [RULE_19] fixed glyph ROM: 256 characters of 5 by 8 dots
// [RULE_20] eight user glyphs; code bits 2..0 form glyph address bits 5..3
// [RULE_21] glyph address bits 2..0 pick row; eighth row ORed with cursor
// [RULE_22] row dots from data bits 4..0, bit 4 leftmost, 1 lit
// [RULE_23] user glyphs when code bits 7..4 zero; bit 3 ignored
// [RULE_24] function set carries bus width bit and two-row bit
// [RULE_25] top bit set: load seven address bits, target text memory
// [RULE_26] bits 7..6 = 01: load six address bits, target glyph memory
// [RULE_27] 4-bit mode: two nibbles on upper lines, high nibble first
// [RULE_28] status reads accepted while busy
module clcd_host_port
  import clcd_pkg::*;
#(
  parameter int LONG_CYCLES = LONG_CYC
)
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic clk_en,
  // interface strap pins
  input wire logic interface_select_high,
  input wire logic interface_select_low,
  // parallel host bus
  input wire logic register_select,
  input wire logic read_write_select,
  input wire logic bus_enable,
  input wire logic [7:0] data_in,
  output logic [7:0] data_out,
  output logic data_oe,
  // fixed glyph rom lookup
  output clcd_rom_req_t rom_req,
  input wire logic [4:0] rom_dots,
  // panel drive
  output clcd_panel_t panel
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  clcd_pins_t pin_raw;
  clcd_pins_t meta_q;
  clcd_pins_t pin_q;
  logic en_prev_q;
  assign pin_raw = '{ifsel: {interface_select_high, interface_select_low},
                     rs: register_select, rw: read_write_select,
                     en: bus_enable, data: data_in};

  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      meta_q <= '0;
      pin_q <= '0;
      en_prev_q <= 1'b0;
    end
    else if (clk_en)
    begin
      meta_q <= pin_raw;
      pin_q <= meta_q;
      en_prev_q <= pin_q.en;
    end
  end

  // ---------------------------------------------------------------
  // access decode
  // ---------------------------------------------------------------
  logic dl_q, two_q, id_q, es_q, disp_q, cur_q, glyph_tgt_q, nib_q, pf_q, clearing_q;
  logic [3:0] hi_q;
  logic [6:0] ac_q, shift_q, clr_idx_q;
  logic [7:0] dr_q;
  logic [16:0] busy_cnt_q;
  logic parallel, take, done, busy, cmd_ok, dw_ok, dr_ok;
  logic [7:0] wr_byte;
  logic [7:0] cmd_top;

  // keep only the highest set bit so a plain case can classify the command
  always_comb
  begin
    cmd_top = 8'h00;
    for (int i = 0; i < 8; i++)
      if (wr_byte[i])
        cmd_top = 8'h01 << i;
  end

  assign parallel = (pin_q.ifsel == IFSEL_PARALLEL); // RULE_01
  assign take = parallel & en_prev_q & ~pin_q.en;
  assign done = take & (dl_q | nib_q); // RULE_27
  assign wr_byte = dl_q ? pin_q.data : {hi_q, pin_q.data[7:4]}; // RULE_27
  assign busy = (busy_cnt_q != 17'h0_0000); // RULE_09
  // commands and data accesses are refused while busy; status never is
  assign cmd_ok = done & ~pin_q.rs & ~pin_q.rw & ~busy; // RULE_07 RULE_09
  assign dw_ok = done & pin_q.rs & ~pin_q.rw & ~busy; // RULE_07
  assign dr_ok = done & pin_q.rs & pin_q.rw & ~busy; // RULE_07

  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      nib_q <= 1'b0;
      hi_q <= 4'h0;
    end
    else if (clk_en)
    begin
      if (dl_q)
        nib_q <= 1'b0;
      else if (take)
      begin
        nib_q <= ~nib_q; // RULE_27
        if (!nib_q)
          hi_q <= pin_q.data[7:4]; // RULE_27
      end
    end
  end

  // ---------------------------------------------------------------
  // address helpers
  // ---------------------------------------------------------------
  function automatic logic [6:0] ac_step(input logic [6:0] ac, input logic up,
                                         input logic glyph, input logic two);
    logic [6:0] r;
    r = up ? ac + 7'h01 : ac - 7'h01;
    if (glyph)
      r = {1'b0, r[5:0]};
    else if (two)
    begin
      if (up && ac == LINE1_LAST) r = LINE2_BASE; // RULE_14
      else if (up && ac == LINE2_LAST) r = 7'h00;
      else if (!up && ac == 7'h00) r = LINE2_LAST;
      else if (!up && ac == LINE2_BASE) r = LINE1_LAST;
    end
    else if (up && ac == ONE_ROW_LAST) r = 7'h00;
    else if (!up && ac == 7'h00) r = ONE_ROW_LAST;
    return r;
  endfunction

  function automatic logic [6:0] sh_next(input logic [6:0] sh, input logic left,
                                         input logic two);
    logic [6:0] mx;
    mx = two ? SHIFT_MAX_TWO : SHIFT_MAX_ONE;
    if (left)
      return (sh >= mx) ? 7'h00 : sh + 7'h01;
    return (sh == 7'h00) ? mx : sh - 7'h01;
  endfunction

  // second row lives at entries 40..79 of the store
  function automatic logic [6:0] t_idx(input logic [6:0] ac, input logic two);
    return (two && ac[6]) ? {1'b0, ac[5:0]} + LINE_LEN : ac; // RULE_14
  endfunction

  // ---------------------------------------------------------------
  // configuration from commands
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      dl_q <= DL_RST;
      two_q <= N_RST;
      id_q <= ID_RST;
      es_q <= 1'b0;
      disp_q <= 1'b0;
      cur_q <= 1'b0;
    end
    else if (clk_en && cmd_ok)
    begin
      case (cmd_top)
        CMD_TEXT_ADDR, CMD_GLYPH_ADDR, CMD_SHIFT, CMD_HOME: ;
        CMD_FUNC:
        begin
          dl_q <= wr_byte[FS_DL]; // RULE_24 RULE_01
          two_q <= wr_byte[FS_N]; // RULE_24
        end
        CMD_DISP:
        begin
          disp_q <= wr_byte[DC_D];
          cur_q <= wr_byte[DC_C];
        end
        CMD_ENTRY:
        begin
          id_q <= wr_byte[EM_ID];
          es_q <= wr_byte[EM_S];
        end
        CMD_CLEAR: id_q <= 1'b1;
        default: ;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // address counter, target and display offset
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      ac_q <= 7'h00;
      shift_q <= 7'h00;
      glyph_tgt_q <= 1'b0;
    end
    else if (clk_en)
    begin
      if (cmd_ok)
      begin
        case (cmd_top)
          CMD_TEXT_ADDR:
          begin
            ac_q <= wr_byte[6:0]; // RULE_25 RULE_16
            glyph_tgt_q <= 1'b0; // RULE_25 RULE_03
          end
          CMD_GLYPH_ADDR:
          begin
            ac_q <= {1'b0, wr_byte[5:0]}; // RULE_26 RULE_16
            glyph_tgt_q <= 1'b1; // RULE_26 RULE_03
          end
          CMD_SHIFT:
            if (wr_byte[SH_SC])
              shift_q <= sh_next(shift_q, ~wr_byte[SH_RL], two_q); // RULE_15
            else
              ac_q <= ac_step(ac_q, wr_byte[SH_RL], glyph_tgt_q, two_q);
          CMD_HOME, CMD_CLEAR:
          begin
            ac_q <= 7'h00;
            shift_q <= 7'h00;
            glyph_tgt_q <= 1'b0;
          end
          default: ;
        endcase
      end
      else if (dw_ok || dr_ok)
      begin
        ac_q <= ac_step(ac_q, id_q, glyph_tgt_q, two_q); // RULE_16
        if (dw_ok && es_q && !glyph_tgt_q)
          shift_q <= sh_next(shift_q, id_q, two_q); // RULE_15
      end
    end
  end

  // ---------------------------------------------------------------
  // character memories and data latch
  // ---------------------------------------------------------------
  logic [7:0] text_mem [80];
  logic [4:0] glyph_mem [GLYPH_DEPTH];
  logic [6:0] widx;
  logic widx_ok;
  logic [7:0] cur_byte;
  assign widx = t_idx(ac_q, two_q);
  assign widx_ok = (widx < TEXT_DEPTH); // RULE_12
  assign cur_byte = glyph_tgt_q ? {3'h0, glyph_mem[ac_q[5:0]]} :
                    (widx_ok ? text_mem[widx] : 8'h00); // RULE_03

  // clear sweeps the store one entry per cycle under the busy window
  always_ff @(posedge sys_clk)
  begin
    if (clk_en)
    begin
      if (clearing_q)
        text_mem[clr_idx_q] <= SPACE_CODE;
      else if (dw_ok && !glyph_tgt_q && widx_ok)
        text_mem[widx] <= wr_byte; // RULE_05 RULE_03
      if (dw_ok && glyph_tgt_q)
        glyph_mem[ac_q[5:0]] <= wr_byte[4:0]; // RULE_05 RULE_22
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      dr_q <= 8'h00;
      pf_q <= 1'b0;
    end
    else if (clk_en)
    begin
      pf_q <= dr_ok | (cmd_ok & wr_byte[7]) | (cmd_ok & wr_byte[7:6] == 2'h1);
      if (dw_ok)
        dr_q <= wr_byte; // RULE_02
      else if (pf_q)
        dr_q <= cur_byte; // RULE_04
    end
  end

  a_write_through: assert property (dw_ok && !glyph_tgt_q && widx_ok |=> // RULE_05
    text_mem[$past(widx)] == $past(wr_byte)) else $error("data write not stored");
  a_read_prefetch: assert property (dr_ok && !busy ##1 1 |=> // RULE_04
    dr_q == $past(cur_byte)) else $error("next byte not prefetched");
  a_text_addr_set: assert property (cmd_ok && wr_byte[7] |=> // RULE_25
    ac_q == $past(wr_byte[6:0]) && !glyph_tgt_q) else $error("text address not set");
  a_glyph_addr_set: assert property (cmd_ok && wr_byte[7:6] == 2'h1 |=> // RULE_26
    ac_q[5:0] == $past(wr_byte[5:0]) && glyph_tgt_q) else $error("glyph address not set");
  a_glyph_ac_step: assert property ((dw_ok || dr_ok) && glyph_tgt_q && id_q |=> // RULE_16
    ac_q[5:0] == $past(ac_q[5:0]) + 6'h01) else $error("address counter did not step");

  // ---------------------------------------------------------------
  // busy timer
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      busy_cnt_q <= 17'h0_0000;
      clearing_q <= 1'b0;
      clr_idx_q <= 7'h00;
    end
    else if (clk_en)
    begin
      if (cmd_ok)
      begin
        busy_cnt_q <= (wr_byte[7:1] == 7'h01 || wr_byte == CMD_CLEAR) ?
                      17'(LONG_CYCLES) : 17'(EXEC_CYC); // RULE_09
        clearing_q <= (wr_byte == CMD_CLEAR);
        clr_idx_q <= 7'h00;
      end
      else
      begin
        if (dw_ok || dr_ok)
          busy_cnt_q <= 17'(EXEC_CYC); // RULE_09
        else if (busy)
          busy_cnt_q <= busy_cnt_q - 17'h0_0001;
        if (clearing_q)
        begin
          clearing_q <= (clr_idx_q != TEXT_DEPTH - 7'h01);
          clr_idx_q <= clr_idx_q + 7'h01;
        end
      end
    end
  end

  a_busy_after_cmd: assert property (cmd_ok && clk_en |=> busy) // RULE_09
    else $error("busy not raised after command");
  a_cmd_refused: assert property (done && busy && !pin_q.rs && clk_en |=> // RULE_09
    $stable(ac_q) && $stable(dl_q)) else $error("command taken while busy");

  // ---------------------------------------------------------------
  // host read path
  // ---------------------------------------------------------------
  // the command latch has no read path; select low returns status only
  logic [7:0] rd_sel;
  logic [7:0] data_out_q;
  assign rd_sel = pin_q.rs ? dr_q : {busy, ac_q}; // RULE_06 RULE_08 RULE_28

  always_ff @(posedge sys_clk)
  begin
    if (reset)
      data_out_q <= 8'h00;
    else if (clk_en)
      data_out_q <= dl_q ? rd_sel : {(nib_q ? rd_sel[3:0] : rd_sel[7:4]), 4'h0}; // RULE_27
  end

  assign data_out = data_out_q;
  assign data_oe = parallel & pin_q.en & pin_q.rw; // RULE_11

  a_status_byte: assert property (clk_en && dl_q && !pin_q.rs |=> // RULE_08
    data_out_q == {$past(busy), $past(ac_q)}) else $error("status byte wrong");
  a_serial_silent: assert property (!parallel |-> !data_oe) // RULE_11
    else $error("bus driven in serial mode");

  // ---------------------------------------------------------------
  // panel scan
  // ---------------------------------------------------------------
  logic [2:0] chr_q, dot_q, s1_dot_q;
  logic [3:0] row_q, s1_row_q;
  logic [6:0] pos, s_idx;
  logic [7:0] s_code;
  logic s1_user_q, s1_cur_q, s1_last_q, dot_bit;
  logic [4:0] s1_glyph_q, dots;
  logic [SEG_W-1:0] chain_q, hold_q;
  logic [COM_W-1:0] com_q;
  clcd_rom_req_t rom_req_q;

  always_comb
  begin
    pos = {4'h0, chr_q} + shift_q; // RULE_15
    if (two_q && pos >= LINE_LEN)
      pos = pos - LINE_LEN;
    else if (!two_q && pos >= TEXT_DEPTH)
      pos = pos - TEXT_DEPTH;
    s_idx = (two_q && row_q[3]) ? pos + LINE_LEN : pos; // RULE_14
  end
  assign s_code = text_mem[s_idx]; // RULE_13

  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      chr_q <= 3'h0;
      dot_q <= 3'h0;
      row_q <= 4'h0;
      rom_req_q <= '0;
      s1_user_q <= 1'b0;
      s1_glyph_q <= 5'h00;
      s1_cur_q <= 1'b0;
      s1_last_q <= 1'b0;
      s1_dot_q <= 3'h0;
      s1_row_q <= 4'h0;
    end
    else if (clk_en)
    begin
      dot_q <= (dot_q == DOT_LAST) ? 3'h0 : dot_q + 3'h1;
      if (dot_q == DOT_LAST)
        chr_q <= chr_q + 3'h1;
      if (dot_q == DOT_LAST && chr_q == CHR_LAST)
        row_q <= (row_q >= (two_q ? ROW_LAST_TWO : ROW_LAST_ONE)) ? 4'h0 : row_q + 4'h1;
      rom_req_q <= '{code: s_code, row: row_q[2:0]}; // RULE_19
      s1_user_q <= (s_code[7:4] == 4'h0); // RULE_23
      s1_glyph_q <= glyph_mem[{s_code[2:0], row_q[2:0]}]; // RULE_20 RULE_21 RULE_23
      s1_cur_q <= cur_q && row_q[2:0] == CURSOR_ROW && !glyph_tgt_q && s_idx == widx;
      s1_last_q <= (dot_q == DOT_LAST && chr_q == CHR_LAST);
      s1_dot_q <= dot_q;
      s1_row_q <= row_q;
    end
  end

  assign dots = s1_user_q ? s1_glyph_q : rom_dots; // RULE_13
  // cursor lands on row eight, so a lit eighth row in a user glyph stays lit
  assign dot_bit = disp_q & (dots[DOT_LAST - s1_dot_q] | s1_cur_q); // RULE_21 RULE_22

  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      chain_q <= '0;
      hold_q <= '0;
      com_q <= '0;
    end
    else if (clk_en)
    begin
      chain_q <= {chain_q[SEG_W-2:0], dot_bit}; // RULE_18
      if (s1_last_q)
      begin
        hold_q <= {chain_q[SEG_W-2:0], dot_bit}; // RULE_18
        com_q <= COM_W'(1) << s1_row_q; // RULE_17
      end
    end
  end

  assign rom_req = rom_req_q;
  assign panel = '{com: com_q, seg: hold_q};

  a_hold_transfer: assert property (s1_last_q && clk_en |=> // RULE_18
    hold_q == chain_q) else $error("holding latch not loaded");
  // commons lag a width change by up to two lines; judge only once one-row has settled
  logic [6:0] one_row_age_q;
  always_ff @(posedge sys_clk)
  begin
    if (reset)
      one_row_age_q <= 7'h00;
    else if (clk_en)
    begin
      if (two_q)
        one_row_age_q <= 7'h00;
      else if (one_row_age_q != 7'h7F)
        one_row_age_q <= one_row_age_q + 7'h01;
    end
  end

  a_one_row_com: assert property (one_row_age_q == 7'h7F |-> // RULE_17
    com_q[COM_W-1:8] == 8'h00) else $error("upper commons active");

endmodule // clcd_host_port

// ---- verification/clcd_host_model.sv ----
`timescale 1ns/1ps
module clcd_host_model
(
  // clock
  input wire logic sys_clk,
  // bus pins toward the device
  output logic rs,
  output logic rw,
  output logic en,
  output logic [7:0] din,
  input wire logic [7:0] dout,
  input wire logic oe,
  // results toward the bench
  output logic rd_valid,
  output logic [7:0] rd_data,
  output logic oe_seen
);
  logic four_bit;

  initial
  begin
    rs = 1'b0;
    rw = 1'b1;
    en = 1'b0;
    din = 8'h5A;
    rd_valid = 1'b0;
    rd_data = 8'h00;
    oe_seen = 1'b0;
    four_bit = 1'b0;
  end

  always @(posedge sys_clk)
    if (oe === 1'b1)
      oe_seen <= 1'b1;

  // ---------------------------------------------------------------
  // one strobe: data held until 4 cycles after enable falls; select/direction held until the next strobe
  // ---------------------------------------------------------------
  task automatic strobe(input logic s, input logic w, input logic [7:0] v,
                        output logic [7:0] q);
    @(posedge sys_clk);
    rs <= s;
    rw <= w;
    din <= w ? ~din : v;
    en <= 1'b1;
    repeat (6) @(posedge sys_clk);
    q = dout;
    en <= 1'b0;
    repeat (4) @(posedge sys_clk);
    // released lines show the inverse, never a stale copy
    din <= ~din;
    repeat (2) @(posedge sys_clk);
  endtask

  task automatic xfer(input logic s, input logic w, input logic [7:0] v, input logic rep,
                      output logic [7:0] q);
    logic [7:0] hi;
    logic [7:0] lo;
    if (four_bit)
    begin
      strobe(s, w, {v[7:4], ~v[3:0]}, hi);
      strobe(s, w, {v[3:0], ~v[7:4]}, lo);
      q = {hi[7:4], lo[7:4]};
    end
    else
      strobe(s, w, v, q);
    if (rep)
    begin
      rd_data <= q;
      rd_valid <= 1'b1;
      @(posedge sys_clk);
      rd_valid <= 1'b0;
    end
  endtask

  // bounded poll, the bench timeout covers a flag stuck high
  task automatic wait_ready();
    logic [7:0] q;
    int n;
    q = 8'h80;
    n = 0;
    while (q[7] !== 1'b0 && n < 600)
    begin
      xfer(1'b0, 1'b1, 8'h00, 1'b0, q);
      n++;
    end
  endtask
endmodule // clcd_host_model

// ---- verification/tb.sv ----
`timescale 1ns/1ps
module tb;
  import clcd_pkg::*;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic isel_hi = 1'b0;
  logic isel_lo = 1'b0;
  logic rs, rw, en, oe, rd_valid, oe_seen;
  logic [7:0] din, dout, rd_data, junk;
  clcd_rom_req_t rom_req;
  logic [4:0] rom_dots;
  clcd_panel_t panel;
  logic [7:0] exp_q[$];
  logic [7:0] r[4];
  logic [31:0] seed = 32'hDF95;
  int num_errors = 0;
  int samples_checked = 0;
  int cycles = 0;

  always #4 sys_clk = ~sys_clk;
  assign rom_dots = rom_req.code[4:0] ^ {2'h0, rom_req.row};

  clcd_host_port #(.LONG_CYCLES(100)) dut (.sys_clk(sys_clk), .reset(reset), .clk_en(1'b1),
    .interface_select_high(isel_hi), .interface_select_low(isel_lo), .register_select(rs),
    .read_write_select(rw), .bus_enable(en), .data_in(din), .data_out(dout), .data_oe(oe),
    .rom_req(rom_req), .rom_dots(rom_dots), .panel(panel));

  clcd_host_model host (.sys_clk(sys_clk), .rs(rs), .rw(rw), .en(en), .din(din),
    .dout(dout), .oe(oe), .rd_valid(rd_valid), .rd_data(rd_data), .oe_seen(oe_seen));

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic finish_test();
    $display("checked %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic cmd(input logic [7:0] c);
    host.xfer(1'b0, 1'b0, c, 1'b0, junk);
    host.wait_ready();
  endtask

  task automatic wdat(input logic [7:0] v);
    host.xfer(1'b1, 1'b0, v, 1'b0, junk);
    host.wait_ready();
  endtask

  task automatic rd(input logic s, input logic [7:0] exp);
    exp_q.push_back(exp);
    host.xfer(s, 1'b1, 8'h00, 1'b1, junk);
    if (s)
      host.wait_ready();
  endtask

  // cleared store: space code through the rom stub lights the row number
  task automatic panel_check(input logic two);
    logic [39:0] exp_seg;
    @(posedge sys_clk);
    exp_seg = '0;
    for (int k = 0; k < 16; k++)
      if (panel.com[k])
        exp_seg = {8{2'b00, 3'(k)}};
    check("commons", {7'h00, $onehot(panel.com)}, 8'h01);
    check("upper commons", two ? 8'h00 : panel.com[15:8], 8'h00);
    for (int b = 0; b < 5; b++)
      check("segments", panel.seg[b*8 +: 8], exp_seg[b*8 +: 8]);
  endtask

  // ---------------------------------------------------------------
  // result watcher and hang guard
  // ---------------------------------------------------------------
  always @(posedge sys_clk)
    if (rd_valid === 1'b1)
    begin
      if (exp_q.size() == 0)
        check("read queue", 8'(exp_q.size()), 8'h01);
      else
        check("read", rd_data, exp_q.pop_front());
    end

  always @(posedge sys_clk)
  begin
    cycles++;
    // about 55k cycles expected; busy windows dominate
    if (cycles == 100000)
    begin
      num_errors++;
      finish_test();
    end
  end

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial
  begin
    for (int i = 0; i < 4; i++)
    begin
      seed = lfsr(lfsr(lfsr(seed)));
      r[i] = seed[7:0];
    end
    repeat (16) @(posedge sys_clk);
    reset <= 1'b0;
    rd(1'b0, 8'h00);
    check("drive enable", {7'h00, oe_seen}, 8'h01);
    host.xfer(1'b0, 1'b0, 8'h85, 1'b0, junk);
    rd(1'b0, 8'h85);
    host.wait_ready();
    wdat(r[0]);
    wdat(r[1]);
    rd(1'b0, 8'h07);
    // commands and data while busy must leave no trace
    host.xfer(1'b0, 1'b0, 8'h85, 1'b0, junk);
    host.xfer(1'b1, 1'b0, ~r[0], 1'b0, junk);
    host.xfer(1'b0, 1'b0, 8'h90, 1'b0, junk);
    host.wait_ready();
    rd(1'b0, 8'h05);
    rd(1'b1, r[0]);
    rd(1'b1, r[1]);
    rd(1'b0, 8'h07);
    cmd(8'h48);
    wdat(8'hFF);
    rd(1'b0, 8'h09);
    cmd(8'h48);
    rd(1'b1, 8'h1F);
    cmd(8'hA7);
    wdat(r[2]);
    rd(1'b0, 8'h40);
    cmd(8'h04);
    wdat(r[3]);
    rd(1'b0, 8'h27);
    // width switches on this command, so the busy poll must already pair nibbles
    host.xfer(1'b0, 1'b0, 8'h28, 1'b0, junk);
    host.four_bit = 1'b1;
    host.wait_ready();
    cmd(8'h85);
    rd(1'b1, r[0]);
    rd(1'b0, 8'h04);
    cmd(8'h18);
    rd(1'b0, 8'h04);
    cmd(8'h10);
    rd(1'b0, 8'h03);
    cmd(8'h01);
    rd(1'b0, 8'h00);
    cmd(8'h85);
    rd(1'b1, 8'h20);
    rd(1'b0, 8'h06);
    cmd(8'h0C);
    panel_check(1'b1);
    cmd(8'h20);
    panel_check(1'b0);
    // serial strap: the bus must stay undriven
    isel_lo <= 1'b1;
    repeat (4) @(posedge sys_clk);
    host.oe_seen = 1'b0;
    host.xfer(1'b0, 1'b1, 8'h00, 1'b0, junk);
    check("serial drive", {7'h00, oe_seen}, 8'h00);
    isel_lo <= 1'b0;
    repeat (4) @(posedge sys_clk);
    rd(1'b0, 8'h06);
    repeat (4) @(posedge sys_clk);
    check("pending", 8'(exp_q.size()), 8'h00);
    finish_test();
  end
endmodule // tb
